// ### bench/flash_page_programming_bench.sv
// self-checking bench for the flash page programming block
`timescale 1ns/10ps
`include "fpp_defines.svh"
module flash_page_programming_bench;
   import fpp_pkg::*;
   localparam logic [7:0] CAL = 8'h5A;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic stb, shi, slo, bs, wr_n, oe_n, rpin_n, sck, mosi, dev_oe_n, rdy, miso;
   fpp_byte_t bus, dev_data, trim;
   int miscompares = 0;
   int cmp_count = 0;
   int ee_mdl [int];
   initial forever #2 i_clk = ~i_clk;
   fpp_top #(.CAL_BYTE(CAL)) fpp_top_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_strobe_clock_input(stb),
      .i_load_select_hi(shi), .i_load_select_lo(slo), .i_byte_select(bs),
      .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(bus), .o_data(dev_data),
      .o_data_oe_n(dev_oe_n), .o_ready_busy_out(rdy), .i_reset_pin_n(rpin_n),
      .i_sck(sck), .i_mosi(mosi), .o_miso(miso), .o_osc_trim_register(trim));
   fpp_prog_model fpp_prog_model_inst (
      .i_clk(i_clk), .i_dev_data(dev_data), .i_dev_oe_n(dev_oe_n), .i_ready(rdy),
      .i_miso(miso), .o_strobe(stb), .o_sel_hi(shi), .o_sel_lo(slo), .o_bs(bs),
      .o_wr_n(wr_n), .o_oe_n(oe_n), .o_bus(bus), .o_rst_pin_n(rpin_n),
      .o_sck(sck), .o_mosi(mosi));
   task automatic note(input string what, input logic bad, input int e, input int g);
      cmp_count++;
      if (bad) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", what, e, g);
      end
   endtask
   task automatic cmp_byte(input string what, input fpp_byte_t exp, input fpp_byte_t got);
      note(what, got !== exp, exp, got);
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      note(what, got !== exp, exp, got);
   endtask
   task automatic cmp_len(input string what, input int lo, input int hi, input int got);
      note(what, got < lo || got > hi, lo, got);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic ee_wr(input int a, input int d);
      fpp_byte_t r;
      fpp_prog_model_inst.spi_xfer({`FPP_SI_WRITE_EE, 7'h00, a[8:0], d[7:0]}, r);
   endtask
   task automatic ee_chk(input int a);
      fpp_byte_t r;
      fpp_prog_model_inst.spi_xfer({`FPP_SI_READ_EE, 7'h00, a[8:0], 8'h00}, r);
      cmp_byte("eeprom byte", ee_mdl.exists(a) ? ee_mdl[a] : `FPP_ERASED_BYTE, r);
   endtask
   initial begin
      #300000;
      miscompares++;
      $display("ERROR watchdog expected end seen timeout");
      final_report();
   end
   initial begin
      fpp_byte_t v;
      logic oe1, oe2;
      int n, pg, adr [3];
      logic [12:0] wa;
      void'($urandom(32'h8b12));
      repeat (12) @(posedge i_clk);
      #1;
      cmp_byte("trim in reset", 8'h00, trim);
      cmp_bit("ready in reset", 1'b1, rdy);
      i_rst = 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      cmp_byte("trim", CAL, trim);
      $display("test reset done");
      fpp_prog_model_inst.par_load(`FPP_XA_CMD, 1'b0, `FPP_CMD_READ_CAL);
      fpp_prog_model_inst.par_load(`FPP_XA_ADDR, 1'b0, `FPP_CAL_ADDR_LO);
      fpp_prog_model_inst.oe_read(v, oe1, oe2);
      cmp_byte("cal byte", CAL, v);
      cmp_bit("bus driven", 1'b0, oe1);
      cmp_bit("bus released", 1'b1, oe2);
      $display("test calibration read done");
      pg = $urandom_range(127);
      fpp_prog_model_inst.par_load(`FPP_XA_CMD, 1'b0, `FPP_CMD_WRITE_FLASH);
      for (int w = 0; w < 64; w++) begin
         wa = {pg[6:0], w[5:0]};
         fpp_prog_model_inst.par_load(`FPP_XA_ADDR, 1'b0, wa[7:0]);
         fpp_prog_model_inst.par_load(`FPP_XA_DATA, 1'b0, 8'($urandom_range(255)));
         fpp_prog_model_inst.par_load(`FPP_XA_DATA, 1'b1, 8'($urandom_range(255)));
      end
      fpp_prog_model_inst.par_load(`FPP_XA_ADDR, 1'b1, {3'h0, wa[12:8]});
      fpp_prog_model_inst.page_strobe(n);
      cmp_len("page busy cycles", 64, 66, n);
      fpp_prog_model_inst.par_load(`FPP_XA_CMD, 1'b0, `FPP_CMD_NOP);
      fpp_prog_model_inst.page_strobe(n);
      cmp_len("busy after nop", 0, 0, n);
      $display("test page program done");
      fpp_prog_model_inst.par_load(`FPP_XA_CMD, 1'b0, `FPP_CMD_CHIP_ERASE);
      fpp_prog_model_inst.page_strobe(n);
      cmp_len("erase busy cycles", 8192, 8194, n);
      ee_mdl.delete();
      cmp_bit("miso idle", 1'b0, miso);
      fpp_prog_model_inst.serial_mode(1'b1);
      for (int i = 0; i < 3; i++) adr[i] = $urandom_range(511);
      ee_wr(adr[0], 8'h00);
      fpp_prog_model_inst.spi_xfer({`FPP_SI_ENABLE, `FPP_SI_ENABLE2, 16'h0000}, v);
      ee_chk(adr[0]);
      for (int i = 0; i < 3; i++) begin
         n = $urandom_range(255);
         ee_wr(adr[i], n);
         ee_wr(adr[i], ~n & 8'hFF);
         ee_mdl[adr[i]] = ~n & 8'hFF;
         ee_chk(adr[i]);
      end
      fpp_prog_model_inst.spi_xfer({`FPP_SI_READ_CAL, 24'h000000}, v);
      cmp_byte("serial trim", CAL, v);
      fpp_prog_model_inst.spi_xfer({`FPP_SI_ENABLE, `FPP_SI_ERASE2, 16'h0000}, v);
      fpp_prog_model_inst.step(8200);
      ee_mdl.delete();
      for (int i = 0; i < 3; i++) ee_chk(adr[i]);
      fpp_prog_model_inst.serial_mode(1'b0);
      $display("test serial download done");
      final_report();
   end
endmodule

// ### bench/fpp_prog_model.sv
// external programmer model: strobed parallel loads and serial download
`timescale 1ns/10ps
module fpp_prog_model (
   // clock
   input wire logic i_clk,
   // device pins seen here
   input wire fpp_pkg::fpp_byte_t i_dev_data,
   input wire logic i_dev_oe_n,
   input wire logic i_ready,
   input wire logic i_miso,
   // pins driven to the device
   output logic o_strobe,
   output logic o_sel_hi,
   output logic o_sel_lo,
   output logic o_bs,
   output logic o_wr_n,
   output logic o_oe_n,
   output fpp_pkg::fpp_byte_t o_bus,
   output logic o_rst_pin_n,
   output logic o_sck,
   output logic o_mosi
);
   import fpp_pkg::*;
   localparam int HALF = 20;
   fpp_byte_t drv = 8'h00;
   fpp_byte_t last = 8'h00;
   logic drv_on = 1'b1;
   // a released bus shows a changing pattern, never a held copy
   always @(posedge i_clk) last <= o_bus;
   assign o_bus = !i_dev_oe_n ? i_dev_data : (drv_on ? drv : ~last);
   initial begin
      {o_strobe, o_sel_hi, o_sel_lo, o_bs, o_sck, o_mosi} = 6'h00;
      {o_wr_n, o_oe_n, o_rst_pin_n} = 3'h7;
   end
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic par_load(input logic [1:0] sel, input logic bs, input fpp_byte_t val);
      step(1);
      {o_sel_hi, o_sel_lo} = sel;
      o_bs = bs;
      drv_on = 1'b1;
      drv = val;
      step(4);
      o_strobe = 1'b1;
      step(4);
      o_strobe = 1'b0;
      step(4);
   endtask
   // write strobe is released after five cycles; the task returns once ready is back
   task automatic page_strobe(output int low_cnt);
      low_cnt = 0;
      step(1);
      o_wr_n = 1'b0;
      for (int t = 0; t < 20000; t++) begin
         step(1);
         if (t == 4) o_wr_n = 1'b1;
         if (i_ready === 1'b0) low_cnt++;
         else if (low_cnt > 0 || t > 12) break;
      end
   endtask
   task automatic oe_read(output fpp_byte_t val, output logic oe_on, output logic oe_off);
      step(1);
      o_bs = 1'b1;
      drv_on = 1'b0;
      o_oe_n = 1'b0;
      step(6);
      val = i_dev_data;
      oe_on = i_dev_oe_n;
      o_oe_n = 1'b1;
      step(6);
      oe_off = i_dev_oe_n;
      drv_on = 1'b1;
   endtask
   // device clock runs throughout serial mode
   task automatic serial_mode(input logic on);
      step(1);
      o_rst_pin_n = !on;
      step(8);
   endtask
   task automatic spi_xfer(input logic [31:0] word, output fpp_byte_t rd);
      rd = 8'h00;
      step(1);
      for (int i = 31; i >= 0; i--) begin
         o_mosi = word[i];
         step(HALF);
         if (i < 8) rd = {rd[6:0], i_miso};
         o_sck = 1'b1;
         step(HALF);
         o_sck = 1'b0;
      end
      step(HALF);
      o_mosi = ~o_mosi;
   endtask
endmodule

// ### rtl/fpp_defines.svh
// constants for the flash page programming block
`ifndef FPP_DEFINES_SVH
`define FPP_DEFINES_SVH
`define FPP_FLASH_AW 13
`define FPP_PAGE_WBITS 6
`define FPP_EE_AW 9
`define FPP_XA_ADDR 2'b00
`define FPP_XA_DATA 2'b01
`define FPP_XA_CMD 2'b10
`define FPP_CMD_NOP 8'h00
`define FPP_CMD_READ_CAL 8'h08
`define FPP_CMD_WRITE_FLASH 8'h10
`define FPP_CMD_CHIP_ERASE 8'h80
`define FPP_CAL_ADDR_LO 8'h00
`define FPP_ERASED_BYTE 8'hFF
`define FPP_ERASED_WORD 16'hFFFF
`define FPP_CAL_DEFAULT 8'h80
`define FPP_SPI_LAST_BIT 6'h1F
`define FPP_SPI_READ_BIT 6'h17
`define FPP_SI_ENABLE 8'hAC
`define FPP_SI_ENABLE2 8'h53
`define FPP_SI_ERASE2 8'h80
`define FPP_SI_LOAD_LO 8'h40
`define FPP_SI_LOAD_HI 8'h48
`define FPP_SI_WRITE_PAGE 8'h4C
`define FPP_SI_WRITE_EE 8'hC0
`define FPP_SI_READ_EE 8'hA0
`define FPP_SI_READ_CAL 8'h38
`endif

// ### rtl/fpp_pkg.sv
// types for the flash page programming block
package fpp_pkg;
   typedef logic [7:0] fpp_byte_t;
   typedef enum logic [2:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_EE_ERASE, ST_EE_WRITE} fpp_state_t;
endpackage

// ### rtl/fpp_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module fpp_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule

// ### rtl/fpp_top.sv
// device-side flash/eeprom programming sequencer, parallel and serial paths
// Behaviour
// - large variant: 64-word pages, word from address bits 5:0, page from 12:6.
// - low address bits pick the word, upper bits pick the page on page write.
// - write strobe low pulse programs the buffered page; ready/busy low until done.
// - no-operation command loaded with load-select 10 resets the internal write state.
// - calibration command, address 0x00, output enable low, byte-select high drives calibration.
// - while the reset pin is low, flash and eeprom are programmed over serial pins.
// - serial eeprom writes erase the byte automatically before writing it.
// - chip erase sets every flash word to 0xFFFF and every eeprom byte to 0xFF.
// - calibration byte is copied into the oscillator trim register once reset is released, and again while the reset pin is low.
`timescale 1ns/10ps
`include "fpp_defines.svh"
module fpp_top #(
   parameter int FLASH_AW = `FPP_FLASH_AW,
   parameter int PAGE_WBITS = `FPP_PAGE_WBITS,
   parameter int EE_AW = `FPP_EE_AW,
   parameter logic [7:0] CAL_BYTE = `FPP_CAL_DEFAULT
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // parallel programming pins
   input wire logic i_strobe_clock_input,
   input wire logic i_load_select_hi,
   input wire logic i_load_select_lo,
   input wire logic i_byte_select,
   input wire logic i_wr_n,
   input wire logic i_oe_n,
   input wire fpp_pkg::fpp_byte_t i_data,
   output fpp_pkg::fpp_byte_t o_data,
   output logic o_data_oe_n,
   output logic o_ready_busy_out,
   // serial programming pins
   input wire logic i_reset_pin_n,
   input wire logic i_sck,
   input wire logic i_mosi,
   output logic o_miso,
   // oscillator trim
   output fpp_pkg::fpp_byte_t o_osc_trim_register
);
   import fpp_pkg::*;

   localparam int PAGE_WORDS = 1 << PAGE_WBITS;
   localparam int PG_W = FLASH_AW - PAGE_WBITS;

   logic [16:0] pins_s;
   logic strobe_s, xa_hi_s, xa_lo_s, bs_s, wr_n_s, oe_n_s, rstpin_n_s, sck_s, mosi_s;
   fpp_byte_t data_s;

   // every pin is asynchronous to i_clk, including the serial clock
   fpp_sync #(.W(17)) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_strobe_clock_input, i_load_select_hi, i_load_select_lo, i_byte_select,
                i_wr_n, i_oe_n, i_data, i_reset_pin_n, i_sck, i_mosi}),
      .o_sync(pins_s)
   );
   assign {strobe_s, xa_hi_s, xa_lo_s, bs_s, wr_n_s, oe_n_s, data_s, rstpin_n_s, sck_s, mosi_s}
      = pins_s;

   logic [15:0] flash_mem [0:(1<<FLASH_AW)-1];
   logic [7:0] ee_mem [0:(1<<EE_AW)-1];
   logic [7:0] pb_lo [0:PAGE_WORDS-1];
   logic [7:0] pb_hi [0:PAGE_WORDS-1];

   fpp_state_t state_q, state_d;
   logic strobe_p_q, strobe_p_d, wr_p_q, wr_p_d, sck_p_q, sck_p_d;
   fpp_byte_t cmd_q, cmd_d, dlo_q, dlo_d, dout_q, dout_d, trim_q, trim_d;
   fpp_byte_t sro_q, sro_d, eed_q, eed_d;
   logic [15:0] addr_q, addr_d;
   logic [FLASH_AW-1:0] cnt_q, cnt_d;
   logic [PG_W-1:0] page_q, page_d;
   logic [EE_AW-1:0] eea_q, eea_d;
   logic [31:0] sri_q, sri_d;
   logic [5:0] bit_q, bit_d;
   logic rdy_q, rdy_d, doe_n_q, doe_n_d, miso_q, miso_d;
   logic trim_ld_q, trim_ld_d, pen_q, pen_d;

   logic ser, strobe_rise, wr_fall, sck_rise, sck_fall;
   logic fl_we, ee_we, pb_we_lo, pb_we_hi;
   logic [FLASH_AW-1:0] fl_addr;
   logic [15:0] fl_wd;
   logic [EE_AW-1:0] ee_addr;
   fpp_byte_t ee_wd, pb_wlo, pb_whi;
   logic [PAGE_WBITS-1:0] pb_idx;

   assign ser = !rstpin_n_s;
   assign strobe_rise = strobe_s && !strobe_p_q;
   assign wr_fall = !wr_n_s && wr_p_q;
   assign sck_rise = sck_s && !sck_p_q;
   assign sck_fall = !sck_s && sck_p_q;

   always_comb begin
      state_d = state_q;
      strobe_p_d = strobe_s;
      wr_p_d = wr_n_s;
      sck_p_d = sck_s;
      cmd_d = cmd_q;
      dlo_d = dlo_q;
      addr_d = addr_q;
      cnt_d = cnt_q;
      page_d = page_q;
      eea_d = eea_q;
      eed_d = eed_q;
      sri_d = sri_q;
      bit_d = bit_q;
      sro_d = sro_q;
      miso_d = miso_q;
      pen_d = pen_q;
      dout_d = dout_q;
      doe_n_d = 1'b1;
      trim_ld_d = 1'b1;
      trim_d = trim_q;
      pb_we_lo = 1'b0;
      pb_we_hi = 1'b0;
      pb_idx = addr_q[PAGE_WBITS-1:0];
      pb_wlo = dlo_q;
      pb_whi = data_s;
      // trim register loads in the first cycle after reset, then reloads for as long as the reset pin is low
      if (!trim_ld_q || ser) begin
         trim_d = CAL_BYTE;
      end
      case (state_q)
         ST_PROG: begin
            if (cnt_q == FLASH_AW'(PAGE_WORDS - 1)) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         ST_ERASE: begin
            if (&cnt_q) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         ST_EE_ERASE: state_d = ST_EE_WRITE;
         ST_EE_WRITE: state_d = ST_IDLE;
         default: begin
            if (!ser && strobe_rise) begin
               case ({xa_hi_s, xa_lo_s})
                  `FPP_XA_ADDR: begin
                     if (bs_s) begin
                        addr_d[15:8] = data_s;
                     end else begin
                        addr_d[7:0] = data_s;
                     end
                  end
                  `FPP_XA_DATA: begin
                     if (bs_s) begin
                        pb_we_lo = 1'b1;
                        pb_we_hi = 1'b1;
                     end else begin
                        dlo_d = data_s;
                     end
                  end
                  // a no-operation command drops any pending write command
                  `FPP_XA_CMD: cmd_d = data_s;
                  default: ;
               endcase
            end else if (!ser && wr_fall) begin
               if (cmd_q == `FPP_CMD_WRITE_FLASH) begin
                  state_d = ST_PROG;
                  page_d = addr_q[FLASH_AW-1:PAGE_WBITS];
                  cnt_d = '0;
               end else if (cmd_q == `FPP_CMD_CHIP_ERASE) begin
                  state_d = ST_ERASE;
                  cnt_d = '0;
               end
            end
         end
      endcase
      if (!ser && !oe_n_s && bs_s && cmd_q == `FPP_CMD_READ_CAL
          && addr_q[7:0] == `FPP_CAL_ADDR_LO) begin
         dout_d = trim_q;
         doe_n_d = 1'b0;
      end
      if (!ser) begin
         bit_d = '0;
         pen_d = 1'b0;
         miso_d = 1'b0;
      end else if (sck_rise) begin
         sri_d = {sri_q[30:0], mosi_s};
         bit_d = bit_q + 1'b1;
         if (bit_q == `FPP_SPI_READ_BIT) begin
            if (sri_d[23:16] == `FPP_SI_READ_EE) begin
               sro_d = ee_mem[sri_d[EE_AW-1:0]];
            end else if (sri_d[23:16] == `FPP_SI_READ_CAL) begin
               sro_d = trim_q;
            end else begin
               sro_d = '0;
            end
         end
         if (bit_q == `FPP_SPI_LAST_BIT) begin
            bit_d = '0;
            if (sri_d[31:24] == `FPP_SI_ENABLE && sri_d[23:16] == `FPP_SI_ENABLE2) begin
               pen_d = 1'b1;
            end else if (pen_q && state_q == ST_IDLE) begin
               pb_idx = sri_d[PAGE_WBITS+7:8];
               pb_wlo = sri_d[7:0];
               pb_whi = sri_d[7:0];
               case (sri_d[31:24])
                  `FPP_SI_ENABLE: begin
                     if (sri_d[23:16] == `FPP_SI_ERASE2) begin
                        state_d = ST_ERASE;
                        cnt_d = '0;
                     end
                  end
                  `FPP_SI_LOAD_LO: pb_we_lo = 1'b1;
                  `FPP_SI_LOAD_HI: pb_we_hi = 1'b1;
                  `FPP_SI_WRITE_PAGE: begin
                     state_d = ST_PROG;
                     page_d = sri_d[FLASH_AW+7:PAGE_WBITS+8];
                     cnt_d = '0;
                  end
                  `FPP_SI_WRITE_EE: begin
                     state_d = ST_EE_ERASE;
                     eea_d = sri_d[EE_AW+7:8];
                     eed_d = sri_d[7:0];
                  end
                  default: ;
               endcase
            end
         end
      end else if (sck_fall) begin
         miso_d = sro_q[7];
         sro_d = {sro_q[6:0], 1'b0};
      end
      rdy_d = (state_d == ST_IDLE);
   end

   // array write ports
   always_comb begin
      fl_we = (state_q == ST_PROG) || (state_q == ST_ERASE);
      fl_addr = (state_q == ST_ERASE) ? cnt_q : {page_q, cnt_q[PAGE_WBITS-1:0]};
      fl_wd = (state_q == ST_ERASE) ? `FPP_ERASED_WORD
            : {pb_hi[cnt_q[PAGE_WBITS-1:0]], pb_lo[cnt_q[PAGE_WBITS-1:0]]};
      ee_we = 1'b0;
      ee_addr = eea_q;
      ee_wd = `FPP_ERASED_BYTE;
      if (state_q == ST_ERASE && cnt_q < FLASH_AW'(1 << EE_AW)) begin
         ee_we = 1'b1;
         ee_addr = cnt_q[EE_AW-1:0];
      end else if (state_q == ST_EE_ERASE) begin
         ee_we = 1'b1;
      end else if (state_q == ST_EE_WRITE) begin
         ee_we = 1'b1;
         ee_wd = eed_q;
      end
   end

   // arrays carry no reset; each entry is known only once a load, a write or a chip erase has set it
   always_ff @(posedge i_clk) begin
      if (fl_we) begin
         flash_mem[fl_addr] <= fl_wd;
      end
      if (ee_we) begin
         ee_mem[ee_addr] <= ee_wd;
      end
      if (pb_we_lo) begin
         pb_lo[pb_idx] <= pb_wlo;
      end
      if (pb_we_hi) begin
         pb_hi[pb_idx] <= pb_whi;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         strobe_p_q <= 1'b0;
         wr_p_q <= 1'b1;
         sck_p_q <= 1'b0;
         cmd_q <= `FPP_CMD_NOP;
         dlo_q <= '0;
         addr_q <= '0;
         cnt_q <= '0;
         page_q <= '0;
         eea_q <= '0;
         eed_q <= '0;
         sri_q <= '0;
         bit_q <= '0;
         sro_q <= '0;
         miso_q <= 1'b0;
         pen_q <= 1'b0;
         dout_q <= '0;
         doe_n_q <= 1'b1;
         rdy_q <= 1'b1;
         trim_ld_q <= 1'b0;
         trim_q <= '0;
      end else begin
         state_q <= state_d;
         strobe_p_q <= strobe_p_d;
         wr_p_q <= wr_p_d;
         sck_p_q <= sck_p_d;
         cmd_q <= cmd_d;
         dlo_q <= dlo_d;
         addr_q <= addr_d;
         cnt_q <= cnt_d;
         page_q <= page_d;
         eea_q <= eea_d;
         eed_q <= eed_d;
         sri_q <= sri_d;
         bit_q <= bit_d;
         sro_q <= sro_d;
         miso_q <= miso_d;
         pen_q <= pen_d;
         dout_q <= dout_d;
         doe_n_q <= doe_n_d;
         rdy_q <= rdy_d;
         trim_ld_q <= trim_ld_d;
         trim_q <= trim_d;
      end
   end

   assign o_data = dout_q;
   assign o_data_oe_n = doe_n_q;
   assign o_ready_busy_out = rdy_q;
   assign o_miso = miso_q;
   assign o_osc_trim_register = trim_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   page_busy_a: assert property (wr_fall && !ser && state_q == ST_IDLE
      && cmd_q == `FPP_CMD_WRITE_FLASH |=> !o_ready_busy_out [*8])
      else $error("ready/busy not low after page write strobe");
   busy_ends_a: assert property ($fell(o_ready_busy_out) && state_q == ST_PROG
      |-> ##[63:66] o_ready_busy_out)
      else $error("page programming did not end in time");
   page_select_a: assert property ($rose(state_q == ST_PROG) && !ser
      |-> page_q == $past(addr_q[FLASH_AW-1:PAGE_WBITS]))
      else $error("wrong page selected for programming");
   word_walk_a: assert property (state_q == ST_PROG && $past(state_q) == ST_PROG
      |-> fl_addr[PAGE_WBITS-1:0] == $past(fl_addr[PAGE_WBITS-1:0]) + 1'b1)
      else $error("page word walk skipped a word");
   nop_clear_a: assert property (strobe_rise && !ser && state_q == ST_IDLE
      && {xa_hi_s, xa_lo_s} == `FPP_XA_CMD && data_s == `FPP_CMD_NOP
      |=> cmd_q == `FPP_CMD_NOP ##1 cmd_q != `FPP_CMD_WRITE_FLASH)
      else $error("no-operation command did not clear write state");
   cal_drive_a: assert property (!ser && !oe_n_s && bs_s && cmd_q == `FPP_CMD_READ_CAL
      && addr_q[7:0] == `FPP_CAL_ADDR_LO |=> !o_data_oe_n && o_data == CAL_BYTE)
      else $error("calibration byte not driven");
   serial_gate_a: assert property (!ser |=> !pen_q)
      else $error("serial enable held outside reset");
   ee_autoerase_a: assert property ($rose(state_q == ST_EE_ERASE)
      |-> ee_we && ee_wd == `FPP_ERASED_BYTE ##1 state_q == ST_EE_WRITE && ee_wd == eed_q)
      else $error("eeprom write without auto-erase");
   erase_ff_a: assert property (state_q == ST_ERASE && $past(state_q) == ST_ERASE
      |-> flash_mem[$past(cnt_q)] == `FPP_ERASED_WORD)
      else $error("erased flash word not 0xFFFF");
   trim_load_a: assert property (ser |=> o_osc_trim_register == CAL_BYTE [*2])
      else $error("trim register not loaded during reset");
endmodule
